// *** design/uart_baud_regs.sv ***
// Purpose: Register file and baud tick generator of an asynchronous serial port.
// Assumes: Classic Wishbone slave, one clock, asynchronous active-low reset.
// Notes: Framing, status flags and wakeup logic live outside this block.
//
// Decided for this implementation: register access over Wishbone.

// ------------------------------------------------------------------
// Top module
// ------------------------------------------------------------------
// Operation
// - Eight registers at base plus byte offsets 0x00-0x1C, four apart.
// - Reserved writes ignored, reserved reads return zero.
// - High register bit 7 enables infrared.
// - Bits 6:5 pick infrared narrow pulse width.
// - Divisor split: five high, eight low bits.
// - Normal rate is clock over sixteen times divisor.
// - Infrared rate is clock over thirty-two times divisor[12:1].
// - Generator stopped until first transmit/receive enable.
// - Zero divisor holds generator disabled.
// - High write staged until low is written.
// - Transmit and receive enables are separate bits.
module uart_baud_regs
    import uart_baud_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic baudTick,
    output logic infraredEnable,
    output logic [5:0] irPulseWidth,
    output logic transmitterEnable,
    output logic receiverEnable,
    output logic generatorRunning
);
    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0] baudHigh;
    logic [7:0] baudHighStage;
    logic [7:0] baudLow;
    logic [7:0] lineCtrlOne;
    logic [7:0] lineCtrlTwo;
    logic [7:0] dataNinth;
    logic [7:0] dataLow;
    gen_state_t genState;
    gen_state_t next_genState;
    logic [12:0] count;
    logic [12:0] next_count;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire logic request = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic [2:0] index = wb_adr_i[WORD_SHIFT+2:WORD_SHIFT];
    wire logic mapped = (wb_adr_i >> (WORD_SHIFT + 3)) == '0;
    wire logic writeByte = request && wb_we_i && mapped && wb_sel_i[0];
    wire logic writeHigh = writeByte && (index == IDX_BAUD_HIGH);
    wire logic writeLow = writeByte && (index == IDX_BAUD_LOW);
    wire logic writeCtrlOne = writeByte && (index == IDX_LINE_CTRL_ONE);
    wire logic writeCtrlTwo = writeByte && (index == IDX_LINE_CTRL_TWO);
    wire logic writeNinth = writeByte && (index == IDX_DATA_NINTH);
    wire logic writeData = writeByte && (index == IDX_DATA_LOW);

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    logic [7:0] readByte;
    always_comb begin
        case (index)
            IDX_BAUD_HIGH: readByte = baudHigh;
            IDX_BAUD_LOW: readByte = baudLow;
            IDX_LINE_CTRL_ONE: readByte = lineCtrlOne;
            IDX_LINE_CTRL_TWO: readByte = lineCtrlTwo;
            IDX_LINE_STAT_ONE: readByte = LINE_STAT_ONE_RESET;
            IDX_LINE_STAT_TWO: readByte = BYTE_ZERO;
            IDX_DATA_NINTH: readByte = dataNinth & DATA_NINTH_MASK;
            IDX_DATA_LOW: readByte = dataLow;
            default: readByte = BYTE_ZERO;
        endcase
    end
    wire logic [7:0] answerByte = mapped ? readByte : BYTE_ZERO;

    // ------------------------------------------------------------------
    // Active configuration
    // ------------------------------------------------------------------
    baud_cfg_t cfg;
    assign cfg.infraredEnable = baudHigh[IR_ENABLE_BIT];
    assign cfg.pulseSelect = baudHigh[PULSE_SEL_HI:PULSE_SEL_LO];
    assign cfg.divisor = {baudHigh[DIV_HIGH_HI:0], baudLow};

    // ------------------------------------------------------------------
    // Divisor reload
    // ------------------------------------------------------------------
    // Infrared mode drops divisor bit zero and doubles the tick period, so a bit stays 16 ticks.
    wire logic [12:0] reloadValue = cfg.infraredEnable ?
        {cfg.divisor[12:1], 1'b0} : cfg.divisor;
    wire logic divisorZero = (reloadValue == '0);
    wire logic txEnable = lineCtrlTwo[TX_ENABLE_BIT];
    wire logic rxEnable = lineCtrlTwo[RX_ENABLE_BIT];
    wire logic tickNow = (genState == GEN_RUNNING) && !divisorZero
        && (count <= 13'h0001);

    // ------------------------------------------------------------------
    // Pulse width select
    // ------------------------------------------------------------------
    logic [5:0] widthSel;
    always_comb begin
        case (cfg.pulseSelect)
            PULSE_QUARTER: widthSel = WIDTH_QUARTER;
            PULSE_THIRTYSECOND: widthSel = WIDTH_THIRTYSECOND;
            PULSE_SIXTEENTH: widthSel = WIDTH_SIXTEENTH;
            PULSE_THREE_SIXTEENTHS: widthSel = WIDTH_THREE_SIXTEENTHS;
            default: widthSel = WIDTH_THREE_SIXTEENTHS;
        endcase
    end

    // ------------------------------------------------------------------
    // Generator state
    // ------------------------------------------------------------------
    always_comb begin
        case (genState)
            GEN_STOPPED: next_genState = (txEnable || rxEnable) ? GEN_RUNNING : GEN_STOPPED;
            GEN_RUNNING: next_genState = GEN_RUNNING;
            default: next_genState = GEN_STOPPED;
        endcase
    end

    always_comb begin
        if (genState != GEN_RUNNING || divisorZero) begin
            next_count = reloadValue;
        end else if (tickNow) begin
            next_count = reloadValue;
        end else begin
            next_count = count - 13'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Baud divisor registers
    // ------------------------------------------------------------------
    // The high byte waits in the stage so that both halves of a new divisor land together.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            baudHighStage <= BAUD_HIGH_RESET;
        end else if (writeHigh) begin
            baudHighStage <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            baudHigh <= BAUD_HIGH_RESET;
        end else if (writeLow) begin
            baudHigh <= baudHighStage;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            baudLow <= BAUD_LOW_RESET;
        end else if (writeLow) begin
            baudLow <= wb_dat_i[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Control and data registers
    // ------------------------------------------------------------------
    // Only the enable bits of the second control byte drive logic here; the rest are storage.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lineCtrlOne <= BYTE_ZERO;
        end else if (writeCtrlOne) begin
            lineCtrlOne <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lineCtrlTwo <= BYTE_ZERO;
        end else if (writeCtrlTwo) begin
            lineCtrlTwo <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dataNinth <= BYTE_ZERO;
        end else if (writeNinth) begin
            dataNinth <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dataLow <= BYTE_ZERO;
        end else if (writeData) begin
            dataLow <= wb_dat_i[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Generator registers
    // ------------------------------------------------------------------
    // Once started the generator state never returns to stopped; a zero divisor parks the counter and holds baudTick and generatorRunning low.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            genState <= GEN_STOPPED;
        end else begin
            genState <= next_genState;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            baudTick <= 1'b0;
        end else begin
            baudTick <= tickNow;
        end
    end

    // ------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------
    // Ack is registered, so every access costs one wait cycle but no combinational path.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= request;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wb_dat_o <= '0;
        end else begin
            wb_dat_o <= request ? {24'h00_0000, answerByte} : '0;
        end
    end

    // ------------------------------------------------------------------
    // Infrared outputs
    // ------------------------------------------------------------------
    // These copies lag the registers by one clock, which the far side tolerates.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            infraredEnable <= 1'b0;
        end else begin
            infraredEnable <= cfg.infraredEnable;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irPulseWidth <= WIDTH_THREE_SIXTEENTHS;
        end else begin
            irPulseWidth <= widthSel;
        end
    end

    // ------------------------------------------------------------------
    // Enable outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            transmitterEnable <= 1'b0;
        end else begin
            transmitterEnable <= txEnable;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            receiverEnable <= 1'b0;
        end else begin
            receiverEnable <= rxEnable;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            generatorRunning <= 1'b0;
        end else begin
            generatorRunning <= (genState == GEN_RUNNING) && !divisorZero;
        end
    end
endmodule : uart_baud_regs

// *** design/uart_baud_pkg.sv ***
// Purpose: Shared constants and types for the serial baud and register block.
// Assumes: Byte-wide registers on a 32-bit classic Wishbone slave, one word each.
// Notes: Byte address is four times the register index.
package uart_baud_pkg;
    // ------------------------------------------------------------------
    // Register indices and addressing
    // ------------------------------------------------------------------
    localparam int REG_COUNT = 8;
    localparam logic [2:0] IDX_BAUD_HIGH = 3'h0;
    localparam logic [2:0] IDX_BAUD_LOW = 3'h1;
    localparam logic [2:0] IDX_LINE_CTRL_ONE = 3'h2;
    localparam logic [2:0] IDX_LINE_CTRL_TWO = 3'h3;
    localparam logic [2:0] IDX_LINE_STAT_ONE = 3'h4;
    localparam logic [2:0] IDX_LINE_STAT_TWO = 3'h5;
    localparam logic [2:0] IDX_DATA_NINTH = 3'h6;
    localparam logic [2:0] IDX_DATA_LOW = 3'h7;
    localparam int WORD_SHIFT = 2;
    localparam int ADDR_WIDTH = 8;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int IR_ENABLE_BIT = 7;
    localparam int PULSE_SEL_HI = 6;
    localparam int PULSE_SEL_LO = 5;
    localparam int DIV_HIGH_HI = 4;
    localparam int TX_ENABLE_BIT = 3;
    localparam int RX_ENABLE_BIT = 2;
    localparam int DIVISOR_WIDTH = 13;
    localparam logic [7:0] BAUD_HIGH_RESET = 8'h00;
    localparam logic [7:0] BAUD_LOW_RESET = 8'h04;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] LINE_STAT_ONE_RESET = 8'hC0;
    localparam logic [7:0] DATA_NINTH_MASK = 8'h40;

    // ------------------------------------------------------------------
    // Oversampling and infrared pulse widths, in sixty-fourths of a bit
    // ------------------------------------------------------------------
    localparam int OVERSAMPLE = 16;
    localparam logic [1:0] PULSE_QUARTER = 2'b11;
    localparam logic [1:0] PULSE_THIRTYSECOND = 2'b10;
    localparam logic [1:0] PULSE_SIXTEENTH = 2'b01;
    localparam logic [1:0] PULSE_THREE_SIXTEENTHS = 2'b00;
    localparam logic [5:0] WIDTH_QUARTER = 6'h10;
    localparam logic [5:0] WIDTH_THIRTYSECOND = 6'h02;
    localparam logic [5:0] WIDTH_SIXTEENTH = 6'h04;
    localparam logic [5:0] WIDTH_THREE_SIXTEENTHS = 6'h0C;

    typedef enum logic [1:0] {
        GEN_STOPPED = 2'b00,
        GEN_RUNNING = 2'b01
    } gen_state_t;

    typedef struct packed {
        logic infraredEnable;
        logic [1:0] pulseSelect;
        logic [12:0] divisor;
    } baud_cfg_t;
endpackage : uart_baud_pkg

// *** verification/uart_baud_props.sv ***
// Purpose: Port-level checks on the register block's bus answers.
// Assumes: The master holds address and direction until ack is sampled.
// Notes: Bound to every instance; tick timing is judged by the bench.
module uart_baud_props
    import uart_baud_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    timeunit 1ns / 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    a_ack_follows: assert property (take_s |=> wb_ack_o) else $error("no ack");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("stray ack");
    a_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == '0) else $error("idle data");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == '0) else $error("upper");
    a_hole_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:5] != 3'h0 |-> wb_dat_o == '0)
        else $error("hole read");
    a_stat_one: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h10 |-> wb_dat_o == 32'hC0)
        else $error("status one");
    a_stat_two: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h14 |-> wb_dat_o == '0)
        else $error("status two");
endmodule : uart_baud_props
bind uart_baud_regs uart_baud_props i_props(.sys_clk(sys_clk), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// *** verification/baud_partner.sv ***
// Purpose: Far-side partner that times the oversampling ticks it is given.
// Assumes: It samples the line once per tick.
// Notes: Only the last gap is kept, so one odd period is not averaged away.
module baud_partner
(
    input wire logic sys_clk,
    input wire logic baudTick,
    output logic [15:0] tickGap = 16'h0000
);
    timeunit 1ns / 1ns;
    logic [15:0] count = 16'h0001;
    always @(posedge sys_clk) begin
        count <= baudTick ? 16'h0001 : count + 16'h0001;
        if (baudTick) tickGap <= count;
    end
endmodule : baud_partner

// *** verification/uart_baud_regs_tb_top.sv ***
// Purpose: Self-checking bench for the baud and register block.
// Assumes: One-cycle ack and byte address four times the register index.
// Notes: Divisors stay small so tick gaps show within a few hundred cycles.
module uart_baud_regs_tb_top import uart_baud_pkg::*; ;
    timeunit 1ns / 1ns;
    logic sys_clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic wb_ack_o, baudTick, infraredEnable, transmitterEnable, receiverEnable, generatorRunning;
    logic [ADDR_WIDTH-1:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, r;
    logic [5:0] irPulseWidth;
    logic [5:0] widths [4] = '{6'h0C, 6'h04, 6'h02, 6'h10};
    logic [15:0] tickGap;
    logic [7:0] hi = 8'h00;
    int miscompares = 0, checks = 0;
    uart_baud_regs i_dut(.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .baudTick(baudTick),
        .infraredEnable(infraredEnable), .irPulseWidth(irPulseWidth),
        .transmitterEnable(transmitterEnable), .receiverEnable(receiverEnable),
        .generatorRunning(generatorRunning));
    baud_partner i_far(.sys_clk(sys_clk), .baudTick(baudTick), .tickGap(tickGap));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) miscompares++;
        if (g !== e) $display("mismatch at %0t got %h exp %h", $time, g, e);
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        do @(posedge sys_clk);
        while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(r, {24'h00_0000, e});
    endtask : rd
    task automatic end_of_test();
        if (miscompares == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    initial forever #5 sys_clk = ~sys_clk;
    initial begin
        repeat (3000) @(posedge sys_clk);
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(8'h04, 8'h04);
        rd(8'h10, 8'hC0);
        rd(8'h14, 8'h00);
        rd(8'h20, 8'h00);
        for (int c = 3; c >= 0; c--) begin
            bus(1'b1, 8'h00, {1'b0, 2'(c), 5'h00});
            rd(8'h00, hi);
            bus(1'b1, 8'h04, 8'h03);
            hi = {1'b0, 2'(c), 5'h00};
            rd(8'h00, hi);
            chk(32'(irPulseWidth), 32'(widths[c]));
        end
        chk(32'(tickGap), 32'h0);
        chk(32'(generatorRunning), 32'h0);
        bus(1'b1, 8'h0C, 8'h08);
        repeat (20) @(posedge sys_clk);
        chk(32'(tickGap), 32'h3);
        chk(32'(transmitterEnable), 32'h1);
        chk(32'(receiverEnable), 32'h0);
        bus(1'b1, 8'h00, 8'h81);
        bus(1'b1, 8'h04, 8'h0B);
        repeat (600) @(posedge sys_clk);
        chk(32'(tickGap), 32'h10A);
        chk(32'(infraredEnable), 32'h1);
        bus(1'b1, 8'h0C, 8'h04);
        repeat (2) @(posedge sys_clk);
        chk(32'(transmitterEnable), 32'h0);
        chk(32'(receiverEnable), 32'h1);
        chk(32'(generatorRunning), 32'h1);
        bus(1'b1, 8'h00, 8'h80);
        bus(1'b1, 8'h20, 8'hFF);
        bus(1'b1, 8'h04, 8'h01);
        repeat (10) @(posedge sys_clk);
        chk(32'(generatorRunning), 32'h0);
        rd(8'h00, 8'h80);
        end_of_test();
    end
endmodule : uart_baud_regs_tb_top
